/* mls_pkg.sv */
`default_nettype none
package mls_pkg;
	// ------------------------------------------------------------
	// Field positions of the modem line status register
	// ------------------------------------------------------------
	localparam int         MLS_CTS_BIT      = 0;
	localparam int         MLS_DSR_BIT      = 1;
	localparam int         MLS_RI_BIT       = 2;
	localparam int         MLS_DCD_BIT      = 3;
	localparam int         MLS_LEVEL_LSB    = 4;
	localparam int         MLS_FLAG_W       = 4;
	localparam int         MLS_STATUS_W     = 8;
	// Modem control register bits used here
	localparam int         MLS_MCR_DTR_BIT  = 0;
	localparam int         MLS_MCR_RTS_BIT  = 1;
	localparam int         MLS_MCR_AUX_OUTPUT_ONE_BIT = 2;
	localparam int         MLS_MCR_AUX_OUTPUT_TWO_BIT = 3;
	localparam int         MLS_MCR_LOOP_BIT = 4;
	localparam int         MLS_MCR_W        = 5;
	// Reset values and fixed codes
	localparam logic [3:0] MLS_FLAGS_RST    = 4'h0;
	localparam logic [7:0] MLS_STATUS_RST   = 8'h00;
	localparam logic [2:0] MLS_IRQ_PRIORITY = 3'h4;
	localparam int         MLS_SYNC_STAGES  = 2;
endpackage : mls_pkg
`default_nettype wire

/* mls_sync_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Synchronised pin levels passed from the input stage to the status logic
interface mls_sync_if;
	logic [3:0] modem_n;
	logic       rd_n;
	logic       sel;
	modport src (output modem_n, output rd_n, output sel);
	modport dst (input modem_n, input rd_n, input sel);
endinterface : mls_sync_if
`default_nettype wire

/* mls_input_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module mls_input_sync (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic [3:0] modem_n_pin,
	input  wire logic rd_n_pin,
	input  wire logic sel_pin,
	mls_sync_if.src   sync
);
	import mls_pkg::*;

	typedef struct packed {
		logic [5:0] stage1;
		logic [5:0] stage2;
	} mls_sync_state_t;

	mls_sync_state_t st_reg;
	mls_sync_state_t st_next;

	// ------------------------------------------------------------
	// Two-flop synchroniser, stage1 feeds stage2 only
	// ------------------------------------------------------------
	always_comb begin
		st_next        = st_reg;
		st_next.stage1 = {sel_pin, rd_n_pin, modem_n_pin};
		st_next.stage2 = st_reg.stage1;
		// Idle pins read high; strobe inactive after reset
		if (!reset_n) begin
			st_next = {6'h1F, 6'h1F};
		end
	end

	always_ff @(posedge ref_clk) begin
		st_reg <= st_next;
	end

	// Only the second stage leaves this module
	assign sync.modem_n = st_reg.stage2[3:0];
	assign sync.rd_n    = st_reg.stage2[4];
	assign sync.sel     = st_reg.stage2[5];
endmodule : mls_input_sync
`default_nettype wire

/* mls_top.sv */
// Overview of operation
// - Each delta flag sets when its modem input changes, the ring flag on its trailing edge only, and all clear when the host reads.
// - A level bit reads 1 while its active-low pin is low and 0 while it is high.
// - With the modem interrupt enabled, the interrupt is raised while any change flag is set.
// - The modem interrupt reports priority level 4, the lowest of the channel.
// - Bit 0 flags clear-to-send, bit 1 data-set-ready, bit 3 carrier-detect changes.
// - Bit 2 sets only on a low-to-high ring indicator pin edge, never on high-to-low.
// - Bits 4 to 7 hold inverted clear-to-send, data-set-ready, ring and carrier levels.
// - In loopback, bits 4 to 7 show the RTS, DTR, output-1 and output-2 control bits.
// - A status read clears only the change flags, the level bits keep following.
// - During a status read, newly arising flags wait until the strobe ends.
// - A flag already set that recurs during a read is cleared at the strobe end.
// - In loopback the pins are ignored and control bit writes still raise changes.
// - Reset clears the change flags; the level bits show the idle pin levels, or the control bits in loopback.
// - Control bit 4 selects loopback, routing the control outputs to the status logic.
`timescale 1ns/100ps
`default_nettype none
module mls_top (
	input  wire logic                          ref_clk,
	input  wire logic                          reset_n,
	input  wire logic                          cts_n,
	input  wire logic                          dsr_n,
	input  wire logic                          ri_n,
	input  wire logic                          dcd_n,
	input  wire logic                          host_read_strobe_n,
	input  wire logic                          modem_status_sel,
	input  wire logic [mls_pkg::MLS_MCR_W-1:0] modem_control_reg,
	input  wire logic                          modem_irq_enable,
	output logic [mls_pkg::MLS_STATUS_W-1:0]   modem_line_status,
	output logic                               modem_irq,
	output logic [2:0]                         modem_irq_level
);
	import mls_pkg::*;

	typedef struct packed {
		logic [3:0] level;   // Inverted levels seen last cycle
		logic [3:0] flags;   // Change flags
		logic [3:0] pend;    // Events seen during a read
		logic       rd_q;    // Read active last cycle
		logic [7:0] status;  // Read data
	} mls_state_t;

	mls_state_t st_reg;
	mls_state_t st_next;
	logic [3:0] level_now;
	logic [3:0] events;
	logic       read_active;
	logic       read_end;

	mls_sync_if sync_bus ();

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	mls_input_sync u_sync (
		.ref_clk     (ref_clk),
		.reset_n     (reset_n),
		.modem_n_pin ({dcd_n, ri_n, dsr_n, cts_n}),
		.rd_n_pin    (host_read_strobe_n),
		.sel_pin     (modem_status_sel),
		.sync        (sync_bus)
	);

	// ------------------------------------------------------------
	// Level source and event detection
	// ------------------------------------------------------------
	// Loopback swaps the pins for the control bits, so a write raises changes
	always_comb begin
		if (modem_control_reg[MLS_MCR_LOOP_BIT]) begin
			level_now = {modem_control_reg[MLS_MCR_AUX_OUTPUT_TWO_BIT],
				modem_control_reg[MLS_MCR_AUX_OUTPUT_ONE_BIT],
				modem_control_reg[MLS_MCR_DTR_BIT],
				modem_control_reg[MLS_MCR_RTS_BIT]};
		end else begin
			level_now = ~sync_bus.modem_n;
		end
	end

	// Per-bit change detectors: any change for the deltas, ring only on its trailing edge.
	// The level register follows the source even in reset, so release raises no false edge.
	for (genvar b = 0; b < MLS_FLAG_W; b++) begin : g_event
		if (b == MLS_RI_BIT) begin : g_ring
			// Inverted level falling means the pin went from low to high
			assign events[b] = st_reg.level[b] & ~level_now[b];
		end else begin : g_delta
			assign events[b] = level_now[b] ^ st_reg.level[b];
		end
	end

	assign read_active = ~sync_bus.rd_n & sync_bus.sel;
	assign read_end    = st_reg.rd_q & ~read_active;

	// ------------------------------------------------------------
	// Flag update
	// ------------------------------------------------------------
	// Flags are frozen during a read so the host never sees them move under the strobe
	always_comb begin
		st_next       = st_reg;
		st_next.level = level_now;
		st_next.rd_q  = read_active;
		if (read_active) begin
			st_next.pend = st_reg.pend | events;
		end else if (read_end) begin
			// Read clears all, deferred events land, recurrences drop
			st_next.flags = events | (st_reg.pend & ~st_reg.flags);
			st_next.pend  = MLS_FLAGS_RST;
		end else begin
			st_next.flags = st_reg.flags | events;
		end
		// Read data held steady while the strobe is low and the status select is high
		if (!read_active) begin
			st_next.status = {level_now, st_next.flags};
		end
		if (!reset_n) begin
			st_next.flags  = MLS_FLAGS_RST;
			st_next.pend   = MLS_FLAGS_RST;
			st_next.rd_q   = 1'b0;
			st_next.status = {level_now, MLS_FLAGS_RST};
		end
	end

	always_ff @(posedge ref_clk) begin
		st_reg <= st_next;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign modem_line_status = st_reg.status;
	assign modem_irq         = modem_irq_enable & (|st_reg.flags);
	assign modem_irq_level   = MLS_IRQ_PRIORITY;
	// No write path exists; software writes have nowhere to land.

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	change_sets_a: assert property (!read_active && events[MLS_CTS_BIT]
		|=> st_reg.flags[MLS_CTS_BIT]) else $error("cts change lost");
	read_clears_a: assert property (read_end && events == 4'h0 && st_reg.pend == 4'h0
		|=> st_reg.flags == 4'h0) else $error("read did not clear flags");
	pin_level_a: assert property (!modem_control_reg[MLS_MCR_LOOP_BIT] && !read_active
		|=> modem_line_status[7:4] == ~$past(sync_bus.modem_n)) else $error("level bad");
	irq_follow_a: assert property (modem_irq_enable && !read_active && events != 4'h0
		|=> modem_irq || !modem_irq_enable) else $error("irq missing");
	irq_level_a: assert property (modem_irq |-> modem_irq_level == 3'h4)
		else $error("irq priority wrong");
	ring_rise_a: assert property (!read_active && !st_reg.flags[MLS_RI_BIT]
		&& !st_reg.level[MLS_RI_BIT] && level_now[MLS_RI_BIT]
		|=> !st_reg.flags[MLS_RI_BIT]) else $error("ring set on wrong edge");
	loop_map_a: assert property (modem_control_reg[MLS_MCR_LOOP_BIT] && !read_active
		|=> modem_line_status[7:4] == {$past(modem_control_reg[3]),
		$past(modem_control_reg[2]), $past(modem_control_reg[0]),
		$past(modem_control_reg[1])}) else $error("loopback level bad");
	read_freeze_a: assert property (read_active && st_reg.rd_q
		|-> $stable(st_reg.flags) && $stable(modem_line_status))
		else $error("status moved during read");
	recur_clear_a: assert property (read_end && st_reg.flags[MLS_DCD_BIT]
		&& st_reg.pend[MLS_DCD_BIT] && !events[MLS_DCD_BIT]
		|=> !st_reg.flags[MLS_DCD_BIT]) else $error("recurring flag kept");
	reset_clear_a: assert property (disable iff (1'b0) !reset_n
		|=> st_reg.flags == 4'h0) else $error("reset left flags");

	// ------------------------------------------------------------
	// Per-bit flag setting outside a read
	// ------------------------------------------------------------
	// Every delta bit gets its own check so a miswired bit cannot hide behind another
	dsr_sets_a: assert property (!read_active && events[MLS_DSR_BIT]
		|=> st_reg.flags[MLS_DSR_BIT]) else $error("dsr change lost");
	dcd_sets_a: assert property (!read_active && events[MLS_DCD_BIT]
		|=> st_reg.flags[MLS_DCD_BIT]) else $error("dcd change lost");
	// Ring flag must rise when the inverted level falls, the opposite of ring_rise_a
	ring_trail_a: assert property (!read_active && st_reg.level[MLS_RI_BIT]
		&& !level_now[MLS_RI_BIT]
		|=> st_reg.flags[MLS_RI_BIT]) else $error("ring trailing edge lost");

	// ------------------------------------------------------------
	// Interrupt gating
	// ------------------------------------------------------------
	// The output is combinational from registered flags, so it may be checked in-cycle
	irq_quiet_a: assert property (!modem_irq_enable |-> !modem_irq)
		else $error("irq while disabled");
	irq_flags_a: assert property (modem_irq_enable && st_reg.flags != 4'h0
		|-> modem_irq) else $error("irq low with flags set");

	// ------------------------------------------------------------
	// Read side effects and loopback pin isolation
	// ------------------------------------------------------------
	// Level bits keep following their source through the clearing edge
	read_level_a: assert property (read_end
		|=> modem_line_status[7:4] == $past(level_now)) else $error("read hit levels");
	// Deferred events must not leak into the next read
	pend_clear_a: assert property (read_end |=> st_reg.pend == 4'h0)
		else $error("pending events kept");
	// With loopback held and the control bits still, pin activity must raise nothing
	pins_ignored_a: assert property (modem_control_reg[MLS_MCR_LOOP_BIT]
		&& $past(modem_control_reg[MLS_MCR_LOOP_BIT])
		&& $stable(modem_control_reg[3:0])
		|-> events == 4'h0) else $error("pin seen in loopback");

	// ------------------------------------------------------------
	// Scenario coverage
	// ------------------------------------------------------------
	read_cycle_c: cover property (read_active ##1 read_active ##[1:8] read_end);
	loop_irq_c:   cover property (modem_control_reg[MLS_MCR_LOOP_BIT] && modem_irq);
	ring_edge_c:  cover property (events[MLS_RI_BIT] && !read_active);
	deferred_c:   cover property (read_active && events != 4'h0 ##[1:8] read_end);
	// A set flag whose event recurs inside the read, the clear-instead-of-set case
	recur_c:      cover property (read_end && (st_reg.flags & st_reg.pend) != 4'h0);
endmodule : mls_top
`default_nettype wire

/* mls_modem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Modem or data set driving the four active-low status pins
// ------------------------------------------------------------
module mls_modem_model (
	input  wire logic [3:0] assert_req,
	output logic            cts_n,
	output logic            dsr_n,
	output logic            ri_n,
	output logic            dcd_n
);
	// Asserted line pulls its pin low; lines are always driven, never released
	assign {dcd_n, ri_n, dsr_n, cts_n} = ~assert_req;
endmodule : mls_modem_model
`default_nettype wire

/* modem_line_status_monitor_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module modem_line_status_monitor_tb_top;
	import mls_pkg::*;
	typedef struct packed {logic [3:0] req; logic [7:0] exp;} mls_row_t;
	logic       ref_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic [3:0] assert_req = 4'h0;
	logic       strobe_n = 1'b1;
	logic       sel = 1'b0;
	logic [4:0] ctrl = 5'h00;
	logic       irq_en = 1'b1;
	logic       cts_n, dsr_n, ri_n, dcd_n, irq;
	logic [7:0] status;
	logic [2:0] irq_lvl;
	int         bad_count = 0;
	int         n_checks = 0;
	// Asserted lines {dcd, ri, dsr, cts} and the status each step should give
	mls_row_t   rows [6] = '{'{4'h1, 8'h11}, '{4'h3, 8'h32}, '{4'h7, 8'h70},
		'{4'h3, 8'h34}, '{4'hB, 8'hB8}, '{4'h0, 8'h0B}};
	// ------------------------------------------------------------
	// Clock, partner and design
	// ------------------------------------------------------------
	always #2 ref_clk = ~ref_clk;
	mls_modem_model u_mls_modem_model (.assert_req(assert_req), .cts_n(cts_n),
		.dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));
	mls_top u_mls_top (.ref_clk(ref_clk), .reset_n(reset_n), .cts_n(cts_n), .dsr_n(dsr_n),
		.ri_n(ri_n), .dcd_n(dcd_n), .host_read_strobe_n(strobe_n), .modem_status_sel(sel),
		.modem_control_reg(ctrl), .modem_irq_enable(irq_en), .modem_line_status(status),
		.modem_irq(irq), .modem_irq_level(irq_lvl));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wait_cyc
	// Status read held three cycles, then time for the trailing-edge update
	// Only reads are ever issued; the status register is never written.
	task automatic host_read();
		strobe_n <= 1'b0;
		sel      <= 1'b1;
		wait_cyc(3);
		strobe_n <= 1'b1;
		sel      <= 1'b0;
		wait_cyc(5);
	endtask : host_read
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out
	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		wait_cyc(5000);
		bad_count++;
		close_out();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		// Two edges of reset; the synchroniser is forced to idle levels meanwhile
		wait_cyc(2);
		reset_n <= 1'b1;
		wait_cyc(2);
		check("reset status", status, 8'h00);
		check("reset irq", {7'h0, irq}, 8'h00);
		check("irq level", {5'h0, irq_lvl}, {5'h0, MLS_IRQ_PRIORITY});
		foreach (rows[i]) begin
			assert_req <= rows[i].req;
			wait_cyc(5);
			check("row status", status, rows[i].exp);
			check("row irq", {7'h0, irq}, {7'h0, |rows[i].exp[3:0]});
			host_read();
			check("row after read", status, {rows[i].exp[7:4], 4'h0});
		end
		// Event during a read: held back, and a recurring set flag is cleared
		assert_req <= 4'h1;
		wait_cyc(5);
		strobe_n <= 1'b0;
		sel      <= 1'b1;
		wait_cyc(4);
		assert_req <= 4'h2;
		wait_cyc(5);
		check("frozen in read", status, 8'h11);
		strobe_n <= 1'b1;
		sel      <= 1'b0;
		wait_cyc(5);
		check("read trailing edge", status, 8'h22);
		host_read();
		// Loopback: pins ignored, control bits drive levels and flags
		ctrl <= 5'h10;
		wait_cyc(5);
		host_read();
		check("loop entry", status, 8'h00);
		assert_req <= 4'hF;
		ctrl       <= 5'h12;
		wait_cyc(5);
		check("loop rts", status, 8'h11);
		host_read();
		ctrl <= 5'h1D;
		wait_cyc(5);
		check("loop others", status, 8'hEB);
		check("loop irq", {7'h0, irq}, 8'h01);
		irq_en <= 1'b0;
		wait_cyc(2);
		check("irq masked", {7'h0, irq}, 8'h00);
		// Mid-run reset: flags clear, loopback levels stay visible
		reset_n <= 1'b0;
		wait_cyc(2);
		reset_n <= 1'b1;
		wait_cyc(2);
		check("mid reset", status, 8'hE0);
		close_out();
	end
endmodule : modem_line_status_monitor_tb_top
`default_nettype wire
